// *** rtl/tcb_defines.svh ***
// Constants for the table call and bank select execution block
// Behaviour
// - Bank select loads register bank 0-3 or memory bank 0,1,15; two cycles.
// - Branch entry loads PC from entry low bits and next byte; three cycles.
// - Compatible call pushes PC into SP-4,-1,-2, flags into SP-3, SP minus four.
// - Extended call: four cycles, PC into SP-6,-3,-4, PC12 SP-5, flags SP-2.
// - Other entries execute the referenced two-byte instruction; three cycles.
// - Six-nibble frame and four cycles only in extended stack mode.
`ifndef TCB_DEFINES_SVH
`define TCB_DEFINES_SVH

// ----------------------------------------
// Cycle counts
// ----------------------------------------
`define TCB_SEL_CYCLES 3'd2
`define TCB_BR_CYCLES 3'd3
`define TCB_EXEC_CYCLES 3'd3
`define TCB_CALL_C_CYCLES 3'd3
`define TCB_CALL_X_CYCLES 3'd4

// ----------------------------------------
// Frame sizes and legal memory banks
// ----------------------------------------
`define TCB_FRAME_C 8'h04
`define TCB_FRAME_X 8'h06
`define TCB_MBANK_HI 4'hF
`define TCB_MBANK_ONE 4'h1
`define TCB_MBANK_ZERO 4'h0

// ----------------------------------------
// Frame slot offsets below SP and last nibble index
// ----------------------------------------
`define TCB_C_SLOT_PCH 8'h04
`define TCB_C_SLOT_PCM 8'h01
`define TCB_C_SLOT_PCL 8'h02
`define TCB_C_SLOT_FLG 8'h03
`define TCB_X_SLOT_PCH 8'h06
`define TCB_X_SLOT_PCM 8'h03
`define TCB_X_SLOT_PCL 8'h04
`define TCB_X_SLOT_P12 8'h05
`define TCB_X_SLOT_FLG 8'h02
`define TCB_C_LAST_IDX 3'h3
`define TCB_X_LAST_IDX 3'h4

`endif

// *** rtl/tcb_pkg.sv ***
// Types for the table call and bank select execution block
package tcb_pkg;
    typedef enum logic [2:0] {
        TCB_CMD_NONE = 3'h0,
        TCB_CMD_SEL_RB = 3'h1,
        TCB_CMD_SEL_MB = 3'h2,
        TCB_CMD_TABLE_REF = 3'h3
    } tcb_cmd_t;
    typedef enum logic [1:0] {
        TCB_ENT_BRANCH = 2'h0,
        TCB_ENT_CALL = 2'h1,
        TCB_ENT_OTHER = 2'h2
    } tcb_entry_t;
    typedef enum logic [2:0] {
        TCB_IDLE = 3'b001,
        TCB_BUSY = 3'b010,
        TCB_DONE = 3'b100
    } tcb_state_t;
endpackage : tcb_pkg

// *** rtl/tcb_stack_writer.sv ***
// Stack frame nibble writer for table calls
`timescale 1ns/10ps
`default_nettype none
`include "tcb_defines.svh"
module tcb_stack_writer (
    // Clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // Frame request
    input wire logic start_i,
    input wire logic ext_mode_i,
    input wire logic [12:0] pc_i,
    input wire logic mem_bank_enable_i,
    input wire logic reg_bank_enable_i,
    input wire logic [7:0] sp_i,
    // Nibble write port
    output logic wr_o,
    output logic [7:0] addr_o,
    output logic [3:0] data_o
);
    // ----------------------------------------
    // Frame sequencer
    // ----------------------------------------
    logic [2:0] idx_r;
    logic busy_r;
    logic ext_r;
    logic [12:0] pc_r;
    logic mem_en_r;
    logic reg_en_r;
    logic [7:0] sp_r;
    wire [2:0] last_w = ext_r ? `TCB_X_LAST_IDX : `TCB_C_LAST_IDX;
    logic [7:0] off_w;
    logic [3:0] nib_w;
    always_comb begin
        off_w = 8'h00;
        nib_w = 4'h0;
        if (ext_r) begin
            unique case (idx_r)
                3'h0: begin
                    off_w = `TCB_X_SLOT_PCH;
                    nib_w = pc_r[11:8];
                end
                3'h1: begin
                    off_w = `TCB_X_SLOT_PCM;
                    nib_w = pc_r[7:4];
                end
                3'h2: begin
                    off_w = `TCB_X_SLOT_PCL;
                    nib_w = pc_r[3:0];
                end
                3'h3: begin
                    off_w = `TCB_X_SLOT_P12;
                    nib_w = {3'h0, pc_r[12]};
                end
                default: begin
                    off_w = `TCB_X_SLOT_FLG;
                    nib_w = {2'h0, mem_en_r, reg_en_r};
                end
            endcase
        end else begin
            unique case (idx_r)
                3'h0: begin
                    off_w = `TCB_C_SLOT_PCH;
                    nib_w = pc_r[11:8];
                end
                3'h1: begin
                    off_w = `TCB_C_SLOT_PCM;
                    nib_w = pc_r[7:4];
                end
                3'h2: begin
                    off_w = `TCB_C_SLOT_PCL;
                    nib_w = pc_r[3:0];
                end
                default: begin
                    off_w = `TCB_C_SLOT_FLG;
                    nib_w = {mem_en_r, reg_en_r, 1'b0, pc_r[12]};
                end
            endcase
        end
    end
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            busy_r <= 1'b0;
            idx_r <= 3'h0;
            ext_r <= 1'b0;
            pc_r <= 13'h0000;
            mem_en_r <= 1'b0;
            reg_en_r <= 1'b0;
            sp_r <= 8'h00;
            wr_o <= 1'b0;
            addr_o <= 8'h00;
            data_o <= 4'h0;
        end else begin
            wr_o <= busy_r;
            addr_o <= sp_r - off_w;
            data_o <= nib_w;
            if (start_i) begin
                busy_r <= 1'b1;
                idx_r <= 3'h0;
                ext_r <= ext_mode_i;
                pc_r <= pc_i;
                mem_en_r <= mem_bank_enable_i;
                reg_en_r <= reg_bank_enable_i;
                sp_r <= sp_i;
            end else if (busy_r) begin
                idx_r <= idx_r + 3'h1;
                busy_r <= (idx_r != last_w);
            end
        end
    end
endmodule : tcb_stack_writer
`default_nettype wire

// *** rtl/tcb_exec.sv ***
// Bank select and table reference execution unit
`timescale 1ns/10ps
`default_nettype none
`include "tcb_defines.svh"
module tcb_exec #(
    parameter bit WIDE_PC = 1'b1
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // Instruction request
    input wire logic start_i,
    input wire logic [2:0] cmd_i,
    input wire logic [3:0] operand_i,
    input wire logic [1:0] entry_kind_i,
    input wire logic [7:0] entry_hi_i,
    input wire logic [7:0] entry_lo_i,
    // Processor state inputs
    input wire logic extended_stack_mode_i,
    input wire logic [12:0] pc_i,
    input wire logic [7:0] sp_i,
    input wire logic mem_bank_enable_i,
    input wire logic reg_bank_enable_i,
    // Results
    output logic busy_o,
    output logic done_o,
    output logic [1:0] reg_bank_select_o,
    output logic [3:0] mem_bank_select_o,
    output logic pc_load_o,
    output logic [12:0] pc_o,
    output logic sp_load_o,
    output logic [7:0] sp_o,
    output logic exec_ref_o,
    output logic [15:0] ref_instr_o,
    output logic illegal_bank_o,
    // Stack nibble writes
    output logic stack_wr_o,
    output logic [7:0] stack_addr_o,
    output logic [3:0] stack_data_o
);
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    tcb_pkg::tcb_state_t state_r;
    logic [2:0] cnt_r;
    logic [2:0] len_r;
    logic [2:0] cmd_r;
    logic [1:0] kind_r;
    logic [12:0] tgt_r;
    logic [7:0] sp_new_r;
    wire take_w = start_i && state_r == tcb_pkg::TCB_IDLE;
    wire is_sel_rb_w = cmd_i == tcb_pkg::TCB_CMD_SEL_RB;
    wire is_sel_mb_w = cmd_i == tcb_pkg::TCB_CMD_SEL_MB;
    wire is_tref_w = cmd_i == tcb_pkg::TCB_CMD_TABLE_REF;
    wire is_call_w = entry_kind_i == tcb_pkg::TCB_ENT_CALL;
    wire is_br_w = entry_kind_i == tcb_pkg::TCB_ENT_BRANCH;
    wire mb_ok_w = operand_i == `TCB_MBANK_ZERO || operand_i == `TCB_MBANK_ONE
        || operand_i == `TCB_MBANK_HI;
    wire hi_bit_w = WIDE_PC ? entry_hi_i[4] : 1'b0;
    wire [12:0] target_w = {hi_bit_w, entry_hi_i[3:0], entry_lo_i};
    wire [12:0] push_pc_w = WIDE_PC ? pc_i : {1'b0, pc_i[11:0]};
    wire [7:0] frame_w = extended_stack_mode_i ? `TCB_FRAME_X : `TCB_FRAME_C;
    wire [2:0] call_len_w = extended_stack_mode_i ? `TCB_CALL_X_CYCLES
        : `TCB_CALL_C_CYCLES;
    wire [2:0] tref_len_w = is_call_w ? call_len_w
        : (is_br_w ? `TCB_BR_CYCLES : `TCB_EXEC_CYCLES);
    wire [2:0] len_w = is_tref_w ? tref_len_w : `TCB_SEL_CYCLES;
    wire call_go_w = take_w && is_tref_w && is_call_w;
    wire last_w = cnt_r == len_r - 3'h1;

    // ----------------------------------------
    // Stack frame writer
    // ----------------------------------------
    tcb_stack_writer u_writer (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .start_i(call_go_w),
        .ext_mode_i(extended_stack_mode_i),
        .pc_i(push_pc_w),
        .mem_bank_enable_i(mem_bank_enable_i),
        .reg_bank_enable_i(reg_bank_enable_i),
        .sp_i(sp_i),
        .wr_o(stack_wr_o),
        .addr_o(stack_addr_o),
        .data_o(stack_data_o)
    );

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            state_r <= tcb_pkg::TCB_IDLE;
            cnt_r <= 3'h0;
            len_r <= 3'h0;
            cmd_r <= 3'h0;
            kind_r <= 2'h0;
            tgt_r <= 13'h0000;
            sp_new_r <= 8'h00;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            reg_bank_select_o <= 2'h0;
            mem_bank_select_o <= 4'h0;
            pc_load_o <= 1'b0;
            pc_o <= 13'h0000;
            sp_load_o <= 1'b0;
            sp_o <= 8'h00;
            exec_ref_o <= 1'b0;
            ref_instr_o <= 16'h0000;
            illegal_bank_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            pc_load_o <= 1'b0;
            sp_load_o <= 1'b0;
            exec_ref_o <= 1'b0;
            unique case (state_r)
                tcb_pkg::TCB_IDLE: begin
                    if (take_w) begin
                        state_r <= tcb_pkg::TCB_BUSY;
                        busy_o <= 1'b1;
                        cnt_r <= 3'h1;
                        len_r <= len_w;
                        cmd_r <= cmd_i;
                        kind_r <= entry_kind_i;
                        tgt_r <= target_w;
                        sp_new_r <= sp_i - frame_w;
                        ref_instr_o <= {entry_hi_i, entry_lo_i};
                        illegal_bank_o <= is_sel_mb_w && !mb_ok_w;
                        if (is_sel_rb_w) begin
                            reg_bank_select_o <= operand_i[1:0];
                        end
                        if (is_sel_mb_w && mb_ok_w) begin
                            mem_bank_select_o <= operand_i;
                        end
                    end
                end
                tcb_pkg::TCB_BUSY: begin
                    cnt_r <= cnt_r + 3'h1;
                    if (last_w) begin
                        state_r <= tcb_pkg::TCB_DONE;
                        busy_o <= 1'b0;
                        done_o <= 1'b1;
                        if (cmd_r == tcb_pkg::TCB_CMD_TABLE_REF) begin
                            if (kind_r == tcb_pkg::TCB_ENT_OTHER) begin
                                exec_ref_o <= 1'b1;
                            end else begin
                                pc_load_o <= 1'b1;
                                pc_o <= tgt_r;
                            end
                            if (kind_r == tcb_pkg::TCB_ENT_CALL) begin
                                sp_load_o <= 1'b1;
                                sp_o <= sp_new_r;
                            end
                        end
                    end
                end
                tcb_pkg::TCB_DONE: begin
                    state_r <= tcb_pkg::TCB_IDLE;
                end
                default: begin
                    state_r <= tcb_pkg::TCB_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Checks: bank select
    // ----------------------------------------
    AST_MB_LEGAL: assert property (@(posedge clock_i) disable iff (srst_i)
        mem_bank_select_o == 4'h0 || mem_bank_select_o == 4'h1 || mem_bank_select_o == 4'hF)
        else $error("memory bank select holds illegal value");
    AST_SEL_TWO: assert property (@(posedge clock_i) disable iff (srst_i)
        take_w && !is_tref_w |-> ##2 done_o)
        else $error("bank select not done in two cycles");
    AST_SEL_RB: assert property (@(posedge clock_i) disable iff (srst_i)
        take_w && is_sel_rb_w |=> (reg_bank_select_o == $past(operand_i[1:0])))
        else $error("register bank select not loaded");
    AST_SEL_MB: assert property (@(posedge clock_i) disable iff (srst_i)
        take_w && is_sel_mb_w && mb_ok_w |=> (mem_bank_select_o == $past(operand_i)))
        else $error("memory bank select not loaded");
    AST_MB_KEEP: assert property (@(posedge clock_i) disable iff (srst_i)
        take_w && is_sel_mb_w && !mb_ok_w |=> ($stable(mem_bank_select_o) && illegal_bank_o))
        else $error("illegal memory bank operand not refused");

    // ----------------------------------------
    // Checks: handshake and table reference
    // ----------------------------------------
    AST_TAKE_BUSY: assert property (@(posedge clock_i) disable iff (srst_i)
        take_w |=> busy_o)
        else $error("busy not raised after take");
    AST_DONE_PULSE: assert property (@(posedge clock_i) disable iff (srst_i)
        done_o |=> !done_o)
        else $error("done longer than one cycle");
    AST_DONE_IDLE: assert property (@(posedge clock_i) disable iff (srst_i)
        done_o |-> !busy_o)
        else $error("busy still high with done");
    AST_BR_THREE: assert property (@(posedge clock_i) disable iff (srst_i)
        take_w && is_tref_w && is_br_w |-> ##3 (pc_load_o && !sp_load_o))
        else $error("branch entry not loaded in three cycles");
    AST_BR_TARGET: assert property (@(posedge clock_i) disable iff (srst_i)
        take_w && is_tref_w && is_br_w |-> ##3 (pc_o == $past(target_w, 3)))
        else $error("branch target wrong");
    AST_CALL_C: assert property (@(posedge clock_i) disable iff (srst_i)
        call_go_w && !extended_stack_mode_i
        |-> ##3 (sp_load_o && sp_o == $past(sp_i, 3) - 8'h04))
        else $error("compatible call frame wrong");
    AST_CALL_PC: assert property (@(posedge clock_i) disable iff (srst_i)
        call_go_w && !extended_stack_mode_i
        |-> ##3 (pc_load_o && pc_o == $past(target_w, 3)))
        else $error("compatible call target wrong");
    AST_CALL_X: assert property (@(posedge clock_i) disable iff (srst_i)
        call_go_w && extended_stack_mode_i
        |-> ##4 (sp_load_o && sp_o == $past(sp_i, 4) - 8'h06))
        else $error("extended call frame wrong");
    AST_EXEC: assert property (@(posedge clock_i) disable iff (srst_i)
        take_w && is_tref_w && !is_br_w && !is_call_w |-> ##3 (exec_ref_o && !pc_load_o))
        else $error("referenced instruction not issued in three cycles");
    AST_REF_WORD: assert property (@(posedge clock_i) disable iff (srst_i)
        take_w && is_tref_w && !is_br_w && !is_call_w
        |-> ##3 (ref_instr_o == $past({entry_hi_i, entry_lo_i}, 3)))
        else $error("referenced instruction word wrong");
    AST_FRAME_X: assert property (@(posedge clock_i) disable iff (srst_i)
        call_go_w && extended_stack_mode_i |-> ##2 stack_wr_o [*5])
        else $error("extended frame not five nibbles");
    AST_FRAME_C: assert property (@(posedge clock_i) disable iff (srst_i)
        call_go_w && !extended_stack_mode_i |-> ##2 stack_wr_o [*4])
        else $error("compatible frame not four nibbles");
    AST_PC12: assert property (@(posedge clock_i) disable iff (srst_i)
        pc_load_o |-> (WIDE_PC || !pc_o[12]))
        else $error("narrow variant loaded PC bit 12");
endmodule : tcb_exec
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the table call and bank select block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    // ----------------------------------------
    // Signals and bookkeeping
    // ----------------------------------------
    typedef struct {int t; int n; logic pl, sl, er, il; logic [12:0] pc; logic [7:0] sp;
        logic [15:0] rf; logic [1:0] rb; logic [3:0] mb;} tcb_note_t;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic start_i = 1'b0, mem_en_i = 1'b0, reg_en_i = 1'b0, ext_i = 1'b0;
    logic [2:0] cmd_i = 3'h0;
    logic [3:0] operand_i = 4'h0;
    logic [1:0] kind_i = 2'h0;
    logic [7:0] hi_i = 8'h00, lo_i = 8'h00, sp_i = 8'h00;
    logic [12:0] pc_i = 13'h0000;
    logic busy_o, done_o, pc_load_o, sp_load_o, exec_ref_o, illegal_bank_o, stack_wr_o;
    logic [1:0] reg_bank_select_o;
    logic [3:0] mem_bank_select_o, stack_data_o;
    logic [12:0] pc_o;
    logic [7:0] sp_o, stack_addr_o;
    logic [15:0] ref_instr_o;
    logic [31:0] seed = 32'h4;
    logic [1:0] rb_m = 2'h0;
    logic [3:0] mb_m = 4'h0;
    int cyc = 0, errors = 0, num_checks = 0;
    tcb_note_t nq[$];
    logic [11:0] sq[$];

    always #50 clock_i = ~clock_i;
    always @(posedge clock_i) cyc <= cyc + 1;

    tcb_exec #(.WIDE_PC(1'b1)) dut_u (.clock_i(clock_i), .srst_i(srst_i), .start_i(start_i),
        .cmd_i(cmd_i), .operand_i(operand_i), .entry_kind_i(kind_i), .entry_hi_i(hi_i),
        .entry_lo_i(lo_i), .extended_stack_mode_i(ext_i), .pc_i(pc_i), .sp_i(sp_i),
        .mem_bank_enable_i(mem_en_i), .reg_bank_enable_i(reg_en_i), .busy_o(busy_o),
        .done_o(done_o), .reg_bank_select_o(reg_bank_select_o),
        .mem_bank_select_o(mem_bank_select_o), .pc_load_o(pc_load_o), .pc_o(pc_o),
        .sp_load_o(sp_load_o), .sp_o(sp_o), .exec_ref_o(exec_ref_o),
        .ref_instr_o(ref_instr_o), .illegal_bank_o(illegal_bank_o), .stack_wr_o(stack_wr_o),
        .stack_addr_o(stack_addr_o), .stack_data_o(stack_data_o));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task final_report;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    // ----------------------------------------
    // Driver: one instruction, notes expected results
    // ----------------------------------------
    task automatic run(input logic [2:0] c, input logic [3:0] op, input logic [1:0] k,
        input logic x);
        tcb_note_t e;
        logic [31:0] r;
        int w;
        r = rnd();
        cmd_i = c;
        operand_i = op;
        kind_i = k;
        ext_i = x;
        hi_i = r[7:0];
        lo_i = r[15:8];
        pc_i = r[28:16];
        mem_en_i = r[29];
        reg_en_i = r[30];
        r = rnd();
        sp_i = r[7:0];
        e = '{default: 0};
        e.t = cyc;
        e.n = 2;
        e.rb = rb_m;
        e.mb = mb_m;
        e.pc = {hi_i[4:0], lo_i};
        e.rf = {hi_i, lo_i};
        if (c == tcb_pkg::TCB_CMD_SEL_RB) begin
            e.rb = op[1:0];
        end else if (c == tcb_pkg::TCB_CMD_SEL_MB) begin
            e.il = !(op == 4'h0 || op == 4'h1 || op == 4'hF);
            e.mb = e.il ? mb_m : op;
        end else if (c == tcb_pkg::TCB_CMD_TABLE_REF) begin
            e.n = 3;
            e.pl = (k != tcb_pkg::TCB_ENT_OTHER);
            e.er = (k == tcb_pkg::TCB_ENT_OTHER);
            if (k == tcb_pkg::TCB_ENT_CALL) begin
                e.sl = 1'b1;
                e.n = x ? 4 : 3;
                e.sp = sp_i - (x ? 8'h06 : 8'h04);
                if (x) begin
                    sq.push_back({sp_i - 8'h06, pc_i[11:8]});
                    sq.push_back({sp_i - 8'h03, pc_i[7:4]});
                    sq.push_back({sp_i - 8'h04, pc_i[3:0]});
                    sq.push_back({sp_i - 8'h05, 3'h0, pc_i[12]});
                    sq.push_back({sp_i - 8'h02, 2'h0, mem_en_i, reg_en_i});
                end else begin
                    sq.push_back({sp_i - 8'h04, pc_i[11:8]});
                    sq.push_back({sp_i - 8'h01, pc_i[7:4]});
                    sq.push_back({sp_i - 8'h02, pc_i[3:0]});
                    sq.push_back({sp_i - 8'h03, mem_en_i, reg_en_i, 1'b0, pc_i[12]});
                end
            end
        end
        rb_m = e.rb;
        mb_m = e.mb;
        nq.push_back(e);
        start_i = 1'b1;
        @(posedge clock_i);
        #10 check("busy", busy_o, 1);
        @(posedge clock_i);
        #10 start_i = 1'b0;
        w = 0;
        while (done_o !== 1'b1 && w < 20) begin
            @(negedge clock_i);
            w++;
        end
        if (w == 20) begin
            errors++;
            final_report();
        end
        repeat (3) @(posedge clock_i);
        #10;
    endtask : run

    // ----------------------------------------
    // Monitor: takes the oldest note per result
    // ----------------------------------------
    always @(negedge clock_i) begin
        tcb_note_t m;
        logic [31:0] sx;
        if (stack_wr_o === 1'b1) begin
            sx = sq.size() ? sq.pop_front() : 0;
            check("stack", {20'h0, stack_addr_o, stack_data_o}, sx);
        end
        if (srst_i === 1'b0 && done_o !== 1'b0) begin
            m = nq.size() ? nq.pop_front() : '{default: 0};
            check("cycles", 32'(cyc - m.t), 32'(m.n));
            check("pulses", {pc_load_o, sp_load_o, exec_ref_o}, {m.pl, m.sl, m.er});
            check("busy", busy_o, 0);
            check("banks", {illegal_bank_o, reg_bank_select_o, mem_bank_select_o},
                {m.il, m.rb, m.mb});
            if (m.pl) check("pc", pc_o, m.pc);
            if (m.sl) check("sp", sp_o, m.sp);
            if (m.er) check("ref", ref_instr_o, m.rf);
        end else begin
            check("idle", {pc_load_o, sp_load_o, exec_ref_o}, 0);
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clock_i);
        #10 srst_i = 1'b0;
        check("reset", {busy_o, done_o, reg_bank_select_o, mem_bank_select_o}, 0);
        check("reset_wr", stack_wr_o, 0);
        for (int i = 0; i < 4; i++) run(tcb_pkg::TCB_CMD_SEL_RB, 4'(i), 2'h0, 1'b0);
        $display("test register bank select done");
        for (int i = 0; i < 16; i++) run(tcb_pkg::TCB_CMD_SEL_MB, 4'(15 - i), 2'h0, 1'b0);
        run(tcb_pkg::TCB_CMD_SEL_MB, 4'h7, 2'h0, 1'b0);
        run(tcb_pkg::TCB_CMD_NONE, 4'h0, 2'h0, 1'b0);
        run(tcb_pkg::TCB_CMD_SEL_MB, 4'hF, 2'h0, 1'b0);
        $display("test memory bank select done");
        for (int i = 0; i < 12; i++) begin
            run(tcb_pkg::TCB_CMD_TABLE_REF, 4'h0, 2'(i % 3), 1'((i / 3) % 2));
        end
        $display("test table reference done");
        check("left", 32'(sq.size() + nq.size()), 0);
        final_report();
    end
endmodule : testbench
`default_nettype wire
